// ---- logic/mipv_pkg.sv ----
// Operation
// - fixed polling order within one priority level
// - supply monitor alone above both user levels
// - temperature pending kept internal, no flags
// - wake event from shutdown makes external pending
// - external flags unchanged while core shut down
// - temperature and serial requests latched until entry
// - clearing serial status keeps latched request
// - clock request follows alarm and interval flags
// - clock vector entry does not clear request
// - multi-source vectors not cleared on entry
// - external flag cleared on entry only if edge
// - low-level external keeps requesting while pin low
// - grant pushes pc, loads vector; return pops
// - vectors from 0x0003 in steps of eight
// - one instruction after return or enable access
// - latency between 3.25 and 16.25 instruction cycles
// - higher level preempts; same level never preempts
// - global enable gates every source
// - priority bit one means high user level
package mipv_pkg;
	localparam int NSRC = 13;
	// polling index, 0 polled first
	localparam logic [3:0] S_PSM  = 4'h0;
	localparam logic [3:0] S_RTC  = 4'h1;
	localparam logic [3:0] S_ADE  = 4'h2;
	localparam logic [3:0] S_WDT  = 4'h3;
	localparam logic [3:0] S_TMP  = 4'h4;
	localparam logic [3:0] S_EX0  = 4'h5;
	localparam logic [3:0] S_CT0  = 4'h6;
	localparam logic [3:0] S_EX1  = 4'h7;
	localparam logic [3:0] S_CT1  = 4'h8;
	localparam logic [3:0] S_SPI  = 4'h9;
	localparam logic [3:0] S_UART = 4'hA;
	localparam logic [3:0] S_CT2  = 4'hB;
	localparam logic [3:0] S_UA2  = 4'hC;
	localparam logic [15:0] VEC_BASE = 16'h0003;
	localparam logic [15:0] VEC_STEP = 16'h0008;
	// vector slot of each polling index
	localparam logic [3:0] VEC_SLOT [NSRC] = '{4'h8, 4'hA, 4'h9, 4'hB, 4'h6, 4'h0,
		4'h1, 4'h2, 4'h3, 4'h7, 4'h4, 4'h5, 4'hC};
	// enable register bits
	localparam int IE_EX0 = 0;
	localparam int IE_CT0 = 1;
	localparam int IE_EX1 = 2;
	localparam int IE_CT1 = 3;
	localparam int IE_UART = 4;
	localparam int IE_CT2 = 5;
	localparam int IE_TMP = 6;
	localparam int IE_GLOBAL = 7;
	localparam int IE2_SPI = 0;
	localparam int IE2_PSM = 1;
	localparam int IE2_RTC = 2;
	localparam int IE2_ADE = 3;
	localparam int IE2_UA2 = 5;
	// priority register bits
	localparam int PR_EX0 = 0;
	localparam int PR_CT0 = 1;
	localparam int PR_EX1 = 2;
	localparam int PR_CT1 = 3;
	localparam int PR_UART = 4;
	localparam int PR_CT2 = 5;
	localparam int PR_TMP = 6;
	localparam int PR_ADE = 7;
	localparam int PR2_SPI = 4;
	localparam int PR2_RTC = 6;
	localparam int PR2_UA2 = 7;
	// counter control bits
	localparam int CC_EX0_EDGE = 0;
	localparam int CC_EX0_FLAG = 1;
	localparam int CC_EX1_EDGE = 2;
	localparam int CC_EX1_FLAG = 3;
	localparam logic [7:0] CC_RESET = 8'h00;
	// latency in quarter instruction cycles
	localparam int LAT_MIN_Q = 13;
	localparam int LAT_MAX_Q = 65;
	localparam int CLK_PER_Q = 1;
	localparam logic [7:0] LAT_MIN_CYC = 8'(LAT_MIN_Q * CLK_PER_Q);
	localparam logic [7:0] LAT_MAX_CYC = 8'(LAT_MAX_Q * CLK_PER_Q);
	localparam logic [2:0] LVL_NONE = 3'h0;
	localparam logic [2:0] LVL_LOW  = 3'h1;
	localparam logic [2:0] LVL_HIGH = 3'h2;
	localparam logic [2:0] LVL_PSM  = 3'h4;
	typedef struct packed {
		logic        valid;
		logic [3:0]  src;
		logic [15:0] addr;
	} mipv_grant_t;
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_WAIT  = 3'b010,
		ST_OFFER = 3'b100
	} mipv_state_t;
endpackage : mipv_pkg

// ---- logic/mipv_ctrl.sv ----
`timescale 1ns/100ps
module mipv_ctrl
	import mipv_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic [7:0]  i_interrupt_enable_reg,
	input  wire logic [7:0]  i_enable_priority2_reg,
	input  wire logic [7:0]  i_priority_select_reg,
	input  wire logic [7:0]  i_counter_control_reg,
	input  wire logic        i_core_shutdown_mode,
	input  wire logic        i_wake_ext0,
	input  wire logic        i_wake_ext1,
	input  wire logic        i_ext0_pin,
	input  wire logic        i_ext1_pin,
	input  wire logic        i_supply_monitor_flag,
	input  wire logic        i_alarm_match_flag,
	input  wire logic        i_interval_elapsed_flag,
	input  wire logic        i_metering_summary_flag,
	input  wire logic        i_watchdog_timeout_flag,
	input  wire logic        i_temperature_adc_pulse,
	input  wire logic        i_counter0_overflow_irq,
	input  wire logic        i_counter1_overflow_irq,
	input  wire logic        i_serial_periph_pulse,
	input  wire logic        i_uart_rx_done_flag,
	input  wire logic        i_uart_tx_done_flag,
	input  wire logic        i_counter2_overflow_flag,
	input  wire logic        i_counter2_external_flag,
	input  wire logic        i_uart2_rx_done_flag,
	input  wire logic        i_uart2_tx_done_flag,
	input  wire logic        i_grant_ack,
	input  wire logic        i_return_from_isr,
	input  wire logic        i_enable_reg_access,
	input  wire logic        i_instr_done,
	output logic             o_irq_req,
	output logic [15:0]      o_vector_addr,
	output logic [3:0]       o_vector_src,
	output logic             o_push_pc,
	output logic             o_ext0_pending_flag,
	output logic             o_ext1_pending_flag,
	output logic             o_counter0_clear,
	output logic             o_counter1_clear,
	output logic [2:0]       o_active_levels
);
	logic [NSRC-1:0] req;
	logic [NSRC-1:0] en;
	logic [NSRC-1:0] hi;
	logic            gen;
	logic            ext0_reg, ext0_next;
	logic            ext1_reg, ext1_next;
	logic            ext0_pin_d_reg, ext1_pin_d_reg;
	logic            tmp_reg, spi_reg;
	logic [2:0]      act_reg;
	logic            block_reg;
	logic [7:0]      lat_reg;
	mipv_state_t     st_reg, st_next;
	mipv_grant_t     gr_reg;
	logic [NSRC-1:0] cand_psm, cand_hi, cand_lo;
	logic [2:0]      lvl_sel;
	logic [NSRC-1:0] cand;
	logic [3:0]      pick;
	logic            pick_ok;
	logic            entry;
	logic [2:0]      top_act;

	// lowest index wins the poll
	function automatic logic [3:0] first_set(input logic [NSRC-1:0] v);
		logic [3:0] r;
		r = 4'h0;
		for (int k = NSRC - 1; k >= 0; k--) begin
			if (v[k]) begin
				r = 4'(k);
			end
		end
		return r;
	endfunction : first_set

	function automatic logic [15:0] vec_of(input logic [3:0] s);
		logic [15:0] slot;
		slot = {12'h000, VEC_SLOT[s]};
		return 16'(VEC_BASE + (slot << 3));
	endfunction : vec_of

	assign entry = i_grant_ack && (st_reg == ST_OFFER);

	// edge detect and wake latch; flags frozen while shut down
	wire ext0_fall = ext0_pin_d_reg && !i_ext0_pin;
	wire ext1_fall = ext1_pin_d_reg && !i_ext1_pin;
	wire ext0_edge = i_counter_control_reg[CC_EX0_EDGE];
	wire ext1_edge = i_counter_control_reg[CC_EX1_EDGE];
	wire ext0_clr  = entry && gr_reg.src == S_EX0 && ext0_edge;
	wire ext1_clr  = entry && gr_reg.src == S_EX1 && ext1_edge;
	wire ext0_set  = !i_core_shutdown_mode && (ext0_edge ? ext0_fall : 1'b0);
	wire ext1_set  = !i_core_shutdown_mode && (ext1_edge ? ext1_fall : 1'b0);

	always_comb begin
		ext0_next = ext0_reg;
		ext1_next = ext1_reg;
		if (ext0_clr) begin
			ext0_next = 1'b0;
		end
		if (ext1_clr) begin
			ext1_next = 1'b0;
		end
		// set wins over clear
		if (ext0_set) begin
			ext0_next = 1'b1;
		end
		if (ext1_set) begin
			ext1_next = 1'b1;
		end
	end

	// wake pending kept apart from the visible flag
	logic wake0_reg, wake1_reg;
	wire  wake0_clr = entry && gr_reg.src == S_EX0;
	wire  wake1_clr = entry && gr_reg.src == S_EX1;

	// request vector in polling order
	assign req[S_PSM]  = i_supply_monitor_flag;
	assign req[S_RTC]  = i_alarm_match_flag || i_interval_elapsed_flag;
	assign req[S_ADE]  = i_metering_summary_flag;
	assign req[S_WDT]  = i_watchdog_timeout_flag;
	assign req[S_TMP]  = tmp_reg;
	assign req[S_EX0]  = ext0_reg || wake0_reg || (!ext0_edge && !i_ext0_pin);
	assign req[S_CT0]  = i_counter0_overflow_irq;
	assign req[S_EX1]  = ext1_reg || wake1_reg || (!ext1_edge && !i_ext1_pin);
	assign req[S_CT1]  = i_counter1_overflow_irq;
	assign req[S_SPI]  = spi_reg;
	assign req[S_UART] = i_uart_rx_done_flag || i_uart_tx_done_flag;
	assign req[S_CT2]  = i_counter2_overflow_flag || i_counter2_external_flag;
	assign req[S_UA2]  = i_uart2_rx_done_flag || i_uart2_tx_done_flag;

	assign gen = i_interrupt_enable_reg[IE_GLOBAL];
	assign en[S_PSM]  = i_enable_priority2_reg[IE2_PSM];
	assign en[S_RTC]  = i_enable_priority2_reg[IE2_RTC];
	assign en[S_ADE]  = i_enable_priority2_reg[IE2_ADE];
	// watchdog interrupt gating lives in the watchdog block
	assign en[S_WDT]  = 1'b1;
	assign en[S_TMP]  = i_interrupt_enable_reg[IE_TMP];
	assign en[S_EX0]  = i_interrupt_enable_reg[IE_EX0];
	assign en[S_CT0]  = i_interrupt_enable_reg[IE_CT0];
	assign en[S_EX1]  = i_interrupt_enable_reg[IE_EX1];
	assign en[S_CT1]  = i_interrupt_enable_reg[IE_CT1];
	assign en[S_SPI]  = i_enable_priority2_reg[IE2_SPI];
	assign en[S_UART] = i_interrupt_enable_reg[IE_UART];
	assign en[S_CT2]  = i_interrupt_enable_reg[IE_CT2];
	assign en[S_UA2]  = i_enable_priority2_reg[IE2_UA2];

	assign hi[S_PSM]  = 1'b0;
	assign hi[S_RTC]  = i_enable_priority2_reg[PR2_RTC];
	assign hi[S_ADE]  = i_priority_select_reg[PR_ADE];
	assign hi[S_WDT]  = 1'b1;
	assign hi[S_TMP]  = i_priority_select_reg[PR_TMP];
	assign hi[S_EX0]  = i_priority_select_reg[PR_EX0];
	assign hi[S_CT0]  = i_priority_select_reg[PR_CT0];
	assign hi[S_EX1]  = i_priority_select_reg[PR_EX1];
	assign hi[S_CT1]  = i_priority_select_reg[PR_CT1];
	assign hi[S_SPI]  = i_enable_priority2_reg[PR2_SPI];
	assign hi[S_UART] = i_priority_select_reg[PR_UART];
	assign hi[S_CT2]  = i_priority_select_reg[PR_CT2];
	assign hi[S_UA2]  = i_enable_priority2_reg[PR2_UA2];

	wire [NSRC-1:0] live = gen ? (req & en) : '0;
	assign cand_psm = live & (NSRC'(1) << S_PSM);
	assign cand_hi  = live & hi & ~(NSRC'(1) << S_PSM);
	assign cand_lo  = live & ~hi & ~(NSRC'(1) << S_PSM);

	// a level may interrupt only when nothing at or above it runs
	assign lvl_sel = (|cand_psm && act_reg[2] == 1'b0) ? LVL_PSM :
		(|cand_hi && act_reg[2:1] == 2'b00) ? LVL_HIGH :
		(|cand_lo && act_reg == 3'b000) ? LVL_LOW : LVL_NONE;
	assign cand = (lvl_sel == LVL_PSM) ? cand_psm :
		(lvl_sel == LVL_HIGH) ? cand_hi :
		(lvl_sel == LVL_LOW) ? cand_lo : '0;
	assign pick    = first_set(cand);
	assign pick_ok = |cand && !block_reg;

	// highest active level ends on return
	assign top_act = act_reg[2] ? LVL_PSM : act_reg[1] ? LVL_HIGH : act_reg[0] ? LVL_LOW : LVL_NONE;

	always_comb begin
		st_next = st_reg;
		case (st_reg)
			ST_IDLE: begin
				if (pick_ok) begin
					st_next = ST_WAIT;
				end
			end
			ST_WAIT: begin
				// hold minimum latency before offering
				if (!pick_ok) begin
					st_next = ST_IDLE;
				end else if (lat_reg >= LAT_MIN_CYC - 8'h01) begin
					st_next = ST_OFFER;
				end
			end
			ST_OFFER: begin
				if (entry) begin
					st_next = ST_IDLE;
				end
			end
			default: begin
				st_next = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			st_reg  <= ST_IDLE;
			lat_reg <= 8'h00;
			gr_reg  <= '0;
		end else begin
			st_reg  <= st_next;
			lat_reg <= (st_reg == ST_WAIT) ? lat_reg + 8'h01 : 8'h00;
			if (st_reg == ST_WAIT && st_next == ST_OFFER) begin
				gr_reg <= '{valid: 1'b1, src: pick, addr: vec_of(pick)};
			end else if (entry) begin
				gr_reg.valid <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			act_reg <= 3'b000;
		end else if (entry) begin
			act_reg <= act_reg | ((gr_reg.src == S_PSM) ? LVL_PSM :
				hi[gr_reg.src] ? LVL_HIGH : LVL_LOW);
		end else if (i_return_from_isr) begin
			act_reg <= act_reg & ~top_act;
		end
	end

	// one instruction must finish after a return or enable access
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			block_reg <= 1'b0;
		end else if (i_return_from_isr || i_enable_reg_access) begin
			block_reg <= 1'b1;
		end else if (i_instr_done) begin
			block_reg <= 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			ext0_reg       <= CC_RESET[CC_EX0_FLAG];
			ext1_reg       <= CC_RESET[CC_EX1_FLAG];
			ext0_pin_d_reg <= 1'b1;
			ext1_pin_d_reg <= 1'b1;
			wake0_reg      <= 1'b0;
			wake1_reg      <= 1'b0;
			tmp_reg        <= 1'b0;
			spi_reg        <= 1'b0;
		end else begin
			ext0_reg       <= ext0_next;
			ext1_reg       <= ext1_next;
			ext0_pin_d_reg <= i_ext0_pin;
			ext1_pin_d_reg <= i_ext1_pin;
			// set wins over clear in every latch below
			wake0_reg <= (i_wake_ext0 && i_core_shutdown_mode) || (wake0_reg && !wake0_clr);
			wake1_reg <= (i_wake_ext1 && i_core_shutdown_mode) || (wake1_reg && !wake1_clr);
			tmp_reg <= i_temperature_adc_pulse ||
				(tmp_reg && !(entry && gr_reg.src == S_TMP));
			// status clears never reach here
			spi_reg <= i_serial_periph_pulse ||
				(spi_reg && !(entry && gr_reg.src == S_SPI));
		end
	end

	assign o_irq_req           = gr_reg.valid;
	assign o_vector_addr       = gr_reg.addr;
	assign o_vector_src        = gr_reg.src;
	assign o_push_pc           = entry;
	assign o_ext0_pending_flag = ext0_reg;
	assign o_ext1_pending_flag = ext1_reg;
	// counter flags are owned by the counters; entry clears them
	assign o_counter0_clear    = entry && gr_reg.src == S_CT0;
	assign o_counter1_clear    = entry && gr_reg.src == S_CT1;
	assign o_active_levels     = act_reg;
endmodule : mipv_ctrl

// ---- testbench/mipv_ctrl_props.sv ----
`timescale 1ns/100ps
module mipv_ctrl_props
	import mipv_pkg::*;
(
	input wire logic        i_clk,
	input wire logic        i_rst,
	input wire logic [7:0]  i_interrupt_enable_reg,
	input wire logic [7:0]  i_counter_control_reg,
	input wire logic        i_core_shutdown_mode,
	input wire logic        i_grant_ack,
	input wire logic        i_return_from_isr,
	input wire logic        o_irq_req,
	input wire logic [15:0] o_vector_addr,
	input wire logic [3:0]  o_vector_src,
	input wire logic        o_push_pc,
	input wire logic        o_ext0_pending_flag,
	input wire logic        o_ext1_pending_flag,
	input wire logic [2:0]  o_active_levels
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	sequence offer_s;
		o_irq_req && !i_grant_ack;
	endsequence
	sequence entry_s;
		o_irq_req && i_grant_ack;
	endsequence
	offer_hold_a: assert property (offer_s |=> o_irq_req && $stable(o_vector_addr))
		else $error("offer dropped or changed before entry");
	pc_push_a: assert property (entry_s |-> o_push_pc ##1 !o_irq_req)
		else $error("entry without push or offer kept");
	vec_addr_a: assert property (o_irq_req |-> o_vector_src <= S_UA2 &&
		o_vector_addr == VEC_BASE + VEC_STEP * 16'(VEC_SLOT[o_vector_src]))
		else $error("vector address off table");
	entry_gap_a: assert property (entry_s |=> !o_irq_req [*8])
		else $error("next offer too soon");
	global_off_a: assert property (!i_interrupt_enable_reg[IE_GLOBAL] && !o_irq_req |=> !o_irq_req)
		else $error("offer with global enable off");
	ret_block_a: assert property (i_return_from_isr && !o_irq_req |=> !o_irq_req [*8])
		else $error("offer right after return");
	edge_clear_a: assert property (entry_s ##0 o_vector_src == S_EX0
		##0 i_counter_control_reg[CC_EX0_EDGE] |=> !o_ext0_pending_flag)
		else $error("edge flag kept after entry");
	sleep_flag_a: assert property (i_core_shutdown_mode [*2]
		|-> $stable(o_ext0_pending_flag) && $stable(o_ext1_pending_flag))
		else $error("external flag moved in shutdown");
	psm_alone_a: assert property (o_irq_req && o_vector_src == S_PSM |-> !o_active_levels[2])
		else $error("supply vector offered in its own routine");
	high_block_a: assert property (o_active_levels[1] && o_irq_req |-> o_vector_src == S_PSM)
		else $error("high routine preempted by user level");
endmodule : mipv_ctrl_props
bind mipv_ctrl mipv_ctrl_props i_props (.i_clk, .i_rst, .i_interrupt_enable_reg,
	.i_counter_control_reg, .i_core_shutdown_mode, .i_grant_ack, .i_return_from_isr,
	.o_irq_req, .o_vector_addr, .o_vector_src, .o_push_pc, .o_ext0_pending_flag,
	.o_ext1_pending_flag, .o_active_levels);

// ---- testbench/mipv_core_model.sv ----
`timescale 1ns/100ps
module mipv_core_model
	import mipv_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic        i_stall,
	input  wire logic        i_irq_req,
	input  wire logic [15:0] i_vector_addr,
	input  wire logic [3:0]  i_vector_src,
	output logic             o_grant_ack,
	output logic             o_instr_done,
	output logic             o_got,
	output logic [15:0]      o_pc_reg,
	output logic [3:0]       o_src_reg
);
	logic [1:0] q_reg;
	// ack rises only while an offer stands, and the offer holds until it is sampled
	always_ff @(posedge i_clk) begin
		q_reg        <= i_rst ? 2'h0 : q_reg + 2'h1;
		o_instr_done <= !i_rst && q_reg == 2'h3; // four quarter cycles per instruction
		o_grant_ack  <= !i_rst && !i_stall && i_irq_req && !o_grant_ack && !o_got;
		o_got        <= o_grant_ack && i_irq_req;
		if (o_grant_ack && i_irq_req) begin
			o_pc_reg  <= i_vector_addr; // vector loaded into the program counter
			o_src_reg <= i_vector_src;
		end
	end
endmodule : mipv_core_model

// ---- testbench/mipv_ctrl_tb.sv ----
`timescale 1ns/100ps
module mipv_ctrl_tb
	import mipv_pkg::*;
;
	// watchdog sits in the high user level, so it is served before the low sources
	localparam int ORD [13] = '{0, 3, 1, 2, 4, 5, 6, 7, 8, 9, 10, 11, 12};
	localparam logic [15:0] EXP [13] = '{16'h0043, 16'h0053, 16'h004B, 16'h005B, 16'h0033,
		16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h003B, 16'h0023, 16'h002B, 16'h0063};
	logic        i_clk, i_rst, i_core_shutdown_mode, i_wake_ext0, i_return_from_isr;
	logic        i_enable_reg_access, stall, ack, idone, got, o_irq_req, o_push_pc;
	logic        o_ext0_pending_flag, o_ext1_pending_flag, o_counter0_clear, o_counter1_clear;
	logic [7:0]  i_interrupt_enable_reg, i_enable_priority2_reg;
	logic [7:0]  i_priority_select_reg, i_counter_control_reg;
	logic [12:0] lv;
	logic [15:0] o_vector_addr, pc;
	logic [3:0]  o_vector_src, srcq;
	logic [2:0]  o_active_levels;
	int          miscompares, n_tests;
	mipv_ctrl i_dut (.i_clk, .i_rst, .i_interrupt_enable_reg, .i_enable_priority2_reg,
		.i_priority_select_reg, .i_counter_control_reg, .i_core_shutdown_mode, .i_wake_ext0,
		.i_wake_ext1(i_wake_ext0), .i_ext0_pin(!lv[5]), .i_ext1_pin(!lv[7]),
		.i_supply_monitor_flag(lv[0]), .i_alarm_match_flag(lv[1]), .i_interval_elapsed_flag(lv[1]),
		.i_metering_summary_flag(lv[2]), .i_watchdog_timeout_flag(lv[3]),
		.i_temperature_adc_pulse(lv[4]), .i_counter0_overflow_irq(lv[6]),
		.i_counter1_overflow_irq(lv[8]), .i_serial_periph_pulse(lv[9]),
		.i_uart_rx_done_flag(lv[10]), .i_uart_tx_done_flag(lv[10]),
		.i_counter2_overflow_flag(lv[11]), .i_counter2_external_flag(lv[11]),
		.i_uart2_rx_done_flag(lv[12]), .i_uart2_tx_done_flag(lv[12]), .i_grant_ack(ack),
		.i_return_from_isr, .i_enable_reg_access, .i_instr_done(idone), .o_irq_req, .o_vector_addr,
		.o_vector_src, .o_push_pc, .o_ext0_pending_flag, .o_ext1_pending_flag, .o_counter0_clear,
		.o_counter1_clear, .o_active_levels);
	mipv_core_model i_core (.i_clk, .i_rst, .i_stall(stall), .i_irq_req(o_irq_req),
		.i_vector_addr(o_vector_addr), .i_vector_src(o_vector_src), .o_grant_ack(ack),
		.o_instr_done(idone), .o_got(got), .o_pc_reg(pc), .o_src_reg(srcq));
	initial begin
		i_clk = 1'b0;
		forever #2 i_clk = ~i_clk;
	end
	task automatic check(input logic ok, input string m);
		n_tests++;
		if (ok !== 1'b1) begin
			miscompares++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask : check
	// counts edges until the core takes a vector; lo is the least legal wait
	task automatic expect_grant(input int k, input int lo);
		int n;
		n = 0;
		while (got !== 1'b1 && n < 300) begin
			@(posedge i_clk);
			n++;
		end
		check(got === 1'b1 && srcq === 4'(k) && pc === EXP[k] && n >= lo && n <= lo + 60, "vector");
		@(posedge i_clk);
	endtask : expect_grant
	task automatic expect_none(input int n);
		int g;
		g = 0;
		repeat (n) begin
			@(posedge i_clk);
			if (got !== 1'b0)
				g++;
		end
		check(g == 0, "unexpected vector");
	endtask : expect_none
	task automatic ret();
		i_return_from_isr <= 1'b1;
		@(posedge i_clk);
		i_return_from_isr <= 1'b0;
		@(posedge i_clk);
	endtask : ret
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : give_verdict
	initial begin
		#80000;
		miscompares++;
		give_verdict();
	end
	initial begin
		{i_rst, stall} = 2'b11;
		{i_core_shutdown_mode, i_wake_ext0, i_return_from_isr, i_enable_reg_access} = 4'h0;
		{miscompares, n_tests, lv} = '0;
		{i_interrupt_enable_reg, i_enable_priority2_reg} = 16'hFF2F;
		{i_priority_select_reg, i_counter_control_reg} = 16'h0005;
		repeat (5) @(posedge i_clk);
		i_rst <= 1'b0;
		@(posedge i_clk);
		lv <= 13'h1FFF;
		@(posedge i_clk);
		lv <= 13'h1DEF;
		// a slow core leaves the offer standing for a while
		repeat (30) @(posedge i_clk);
		stall <= 1'b0;
		for (int k = 0; k < 13; k++) begin
			expect_grant(ORD[k], 0);
			lv[ORD[k]] <= 1'b0;
			ret();
		end
		i_priority_select_reg <= 8'h08;
		lv[6] <= 1'b1;
		expect_grant(6, 14);
		lv[8] <= 1'b1;
		lv[10] <= 1'b1;
		expect_grant(8, 0);
		expect_none(40);
		lv <= 13'h0400;
		ret();
		expect_none(30);
		ret();
		expect_grant(10, 0);
		lv <= '0;
		ret();
		{i_interrupt_enable_reg, i_enable_priority2_reg, i_enable_reg_access} <= 17'h0FE01;
		lv <= 13'h0242;
		@(posedge i_clk);
		i_enable_reg_access <= 1'b0;
		lv <= 13'h0040;
		expect_none(40);
		{i_interrupt_enable_reg, i_enable_priority2_reg} <= 16'hFF05;
		expect_grant(6, 14);
		lv <= '0;
		ret();
		expect_grant(9, 0);
		ret();
		lv[1] <= 1'b1;
		expect_grant(1, 0);
		ret();
		expect_grant(1, 0);
		lv <= '0;
		ret();
		expect_none(40);
		i_counter_control_reg <= 8'h00;
		lv[5] <= 1'b1;
		expect_grant(5, 0);
		ret();
		expect_grant(5, 0);
		lv[5] <= 1'b0;
		ret();
		expect_none(40);
		{i_counter_control_reg, i_interrupt_enable_reg, i_core_shutdown_mode} <= 17'h00A01;
		@(posedge i_clk);
		i_wake_ext0 <= 1'b1;
		lv[5] <= 1'b1;
		@(posedge i_clk);
		i_wake_ext0 <= 1'b0;
		lv[5] <= 1'b0;
		repeat (3) @(posedge i_clk);
		check(o_ext0_pending_flag === 1'b0 && o_ext1_pending_flag === 1'b0, "flag moved");
		{i_interrupt_enable_reg, i_core_shutdown_mode} <= 9'h102;
		expect_grant(5, 0);
		ret();
		expect_none(40);
		give_verdict();
	end
endmodule : mipv_ctrl_tb
